// file: design/pmnp_next_page.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmnp_regs.svh"

module pmnp_next_page
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic base_page_sent,
  input wire logic base_toggle_bit,
  input wire logic np_load,
  input wire logic np_more_pages,
  input wire logic np_message_page,
  input wire logic np_comply,
  input wire pmnp_pkg::pmnp_code_t np_code,
  input wire logic np_exchanged,
  output pmnp_pkg::pmnp_word_t np_word
);
  import pmnp_pkg::*;

  logic more_reg, more_next;
  logic msg_reg, msg_next;
  logic comply_reg, comply_next;
  logic toggle_reg, toggle_next;
  pmnp_code_t code_reg, code_next;

  always_comb
  begin
    more_next = more_reg;
    msg_next = msg_reg;
    comply_next = comply_reg;
    code_next = code_reg;
    toggle_next = toggle_reg;
    if (np_load)
    begin
      more_next = np_more_pages;
      msg_next = np_message_page;
      comply_next = np_comply;
      code_next = np_code;
    end
    if (base_page_sent)
      toggle_next = ~base_toggle_bit;
    else if (np_exchanged)
      toggle_next = ~toggle_reg;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      more_reg <= 1'b0;
      msg_reg <= `PMNP_MSG_PAGE_RST;
      comply_reg <= 1'b0;
      toggle_reg <= 1'b0;
      code_reg <= `PMNP_CODE_RST;
    end
    else
    begin
      more_reg <= more_next;
      msg_reg <= msg_next;
      comply_reg <= comply_next;
      toggle_reg <= toggle_next;
      code_reg <= code_next;
    end
  end

  // Bit 14 reserved, reads zero
  assign np_word = {more_reg, 1'b0, msg_reg, comply_reg, toggle_reg, code_reg};

  AST_TOGGLE_BASE: assert property (@(posedge core_clk) disable iff (!resetn)
    base_page_sent |=> np_word[`PMNP_BIT_TOGGLE] == !$past(base_toggle_bit))
    else $error("toggle not inverse of base codeword bit");

  AST_TOGGLE_FLIP: assert property (@(posedge core_clk) disable iff (!resetn)
    (np_exchanged && !base_page_sent) |=> $changed(np_word[`PMNP_BIT_TOGGLE]))
    else $error("toggle did not flip after exchange");

  AST_TOGGLE_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    (!np_exchanged && !base_page_sent) |=> $stable(np_word[`PMNP_BIT_TOGGLE]))
    else $error("toggle changed without exchange");

  AST_FIELDS_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    np_load |=> np_word[`PMNP_BIT_MORE_PAGES] == $past(np_more_pages)
      && np_word[`PMNP_BIT_MSG_PAGE] == $past(np_message_page)
      && np_word[`PMNP_BIT_COMPLY] == $past(np_comply)
      && np_word[10:0] == $past(np_code))
    else $error("next page fields not loaded");
endmodule
`default_nettype wire

// file: design/pmnp_pkg.sv
package pmnp_pkg;
  `include "pmnp_regs.svh"

  typedef enum logic [1:0] {
    PMNP_BUS_RSVD0 = 2'h0,
    PMNP_BUS_RSVD1 = 2'h1,
    PMNP_BUS_SPI = 2'h2,
    PMNP_BUS_MDIO = 2'h3
  } pmnp_bus_mode_t;

  typedef enum {
    PMNP_STRAP_SYNC1,
    PMNP_STRAP_SYNC2,
    PMNP_STRAP_CAPTURE,
    PMNP_STRAP_DONE
  } pmnp_strap_state_t;

  typedef logic [15:0] pmnp_word_t;
  typedef logic [10:0] pmnp_code_t;
endpackage

// file: design/pmnp_regs.svh
`ifndef PMNP_REGS_SVH
`define PMNP_REGS_SVH

// Register byte offsets
`define PMNP_OFS_MEDIA_MODE 12'h00d8
`define PMNP_OFS_NP_TX 12'h00dc

// Media and host bus mode register fields
`define PMNP_BIT_P2_COPPER 7
`define PMNP_BIT_P1_COPPER 6
`define PMNP_RO_HI_RST 8'h00
`define PMNP_RO_54_RST 2'h3
`define PMNP_RW_32_RST 2'h3
`define PMNP_COPPER_RST 1'h1

// Next page transmit register fields
`define PMNP_BIT_MORE_PAGES 15
`define PMNP_BIT_NP_RSVD 14
`define PMNP_BIT_MSG_PAGE 13
`define PMNP_BIT_COMPLY 12
`define PMNP_BIT_TOGGLE 11
`define PMNP_MSG_PAGE_RST 1'h1
`define PMNP_CODE_RST 11'h001

`endif

// file: design/pmnp_top.sv
// Functional notes
// - At reset the bus mode field loads the strap levels on receive pins.
// - Bit 7 picks port 2 media: 1 copper (default), 0 fiber bypassing coding.
// - Bit 6 picks port 1 media: 1 copper (default), 0 fiber bypassing coding.
// - Bus mode 10 is SPI slave, 11 is MDIO access; 00 and 01 reserved.
// - Next page bit 15 shows that further next pages follow.
// - Next page bit 13 marks message page, resets to one.
// - Next page bit 12 shows ability to comply with received message.
// - Toggle bit inverts the previous exchanged codeword toggle, except when a base page is sent in the same cycle.
// - First next page toggle is inverse of base codeword bit 11.
// - Bits 10:0 hold the code field, reset 0x001; register read-only.
`timescale 1ns/1ps
`default_nettype none
`include "pmnp_regs.svh"

module pmnp_top
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] strap_rxd,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire pmnp_pkg::pmnp_word_t reg_wdata,
  output pmnp_pkg::pmnp_word_t reg_rdata,
  output logic reg_rvalid,
  input wire logic base_page_sent,
  input wire logic base_toggle_bit,
  input wire logic np_load,
  input wire logic np_more_pages,
  input wire logic np_message_page,
  input wire logic np_comply,
  input wire pmnp_pkg::pmnp_code_t np_code,
  input wire logic np_exchanged,
  output logic port1_fiber,
  output logic port2_fiber,
  output logic host_spi_sel,
  output logic host_mdio_sel,
  output logic host_mode_invalid
);
  import pmnp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser and capture

  logic [1:0] strap_s1_reg, strap_s2_reg;
  pmnp_strap_state_t strap_st_reg, strap_st_next;

  always_comb
  begin
    strap_st_next = strap_st_reg;
    case (strap_st_reg)
      PMNP_STRAP_SYNC1: strap_st_next = PMNP_STRAP_SYNC2;
      PMNP_STRAP_SYNC2: strap_st_next = PMNP_STRAP_CAPTURE;
      // Second stage holds the pin level only from here on
      PMNP_STRAP_CAPTURE: strap_st_next = PMNP_STRAP_DONE;
      default: strap_st_next = PMNP_STRAP_DONE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
      strap_st_reg <= PMNP_STRAP_SYNC1;
    end
    else
    begin
      strap_s1_reg <= strap_rxd;
      strap_s2_reg <= strap_s1_reg;
      strap_st_reg <= strap_st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Media and host bus mode register

  logic p2_copper_reg, p2_copper_next;
  logic p1_copper_reg, p1_copper_next;
  logic [1:0] rw32_reg, rw32_next;
  logic [1:0] bus_mode_reg, bus_mode_next;
  logic wr_media, rd_media, rd_np;
  pmnp_word_t media_word, np_word;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  always_comb
  begin
    wr_media = 1'b0;
    rd_media = 1'b0;
    rd_np = 1'b0;
    if (hit(reg_addr, `PMNP_OFS_MEDIA_MODE))
    begin
      wr_media = reg_wr;
      rd_media = reg_rd;
    end
    else if (hit(reg_addr, `PMNP_OFS_NP_TX))
      rd_np = reg_rd;
  end

  always_comb
  begin
    p2_copper_next = p2_copper_reg;
    p1_copper_next = p1_copper_reg;
    rw32_next = rw32_reg;
    bus_mode_next = bus_mode_reg;
    if (strap_st_reg == PMNP_STRAP_CAPTURE)
      bus_mode_next = strap_s2_reg;
    else if (wr_media)
    begin
      p2_copper_next = reg_wdata[`PMNP_BIT_P2_COPPER];
      p1_copper_next = reg_wdata[`PMNP_BIT_P1_COPPER];
      rw32_next = reg_wdata[3:2];
      bus_mode_next = reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      p2_copper_reg <= `PMNP_COPPER_RST;
      p1_copper_reg <= `PMNP_COPPER_RST;
      rw32_reg <= `PMNP_RW_32_RST;
      bus_mode_reg <= 2'h0;
    end
    else
    begin
      p2_copper_reg <= p2_copper_next;
      p1_copper_reg <= p1_copper_next;
      rw32_reg <= rw32_next;
      bus_mode_reg <= bus_mode_next;
    end
  end

  // Reserved fields 15:8 and 5:4 are constants, writes cannot reach them
  assign media_word = {`PMNP_RO_HI_RST, p2_copper_reg, p1_copper_reg,
    `PMNP_RO_54_RST, rw32_reg, bus_mode_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Next page transmit codeword

  pmnp_next_page u_next_page
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .base_page_sent(base_page_sent),
    .base_toggle_bit(base_toggle_bit),
    .np_load(np_load),
    .np_more_pages(np_more_pages),
    .np_message_page(np_message_page),
    .np_comply(np_comply),
    .np_code(np_code),
    .np_exchanged(np_exchanged),
    .np_word(np_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data and decoded outputs

  pmnp_word_t rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic p1_fiber_reg, p2_fiber_reg, spi_reg, mdio_reg, inval_reg;

  always_comb
  begin
    rvalid_next = reg_rd;
    rdata_next = 16'h0000;
    if (rd_media)
      rdata_next = media_word;
    else if (rd_np)
      rdata_next = np_word;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      p1_fiber_reg <= 1'b0;
      p2_fiber_reg <= 1'b0;
      spi_reg <= 1'b0;
      mdio_reg <= 1'b0;
      inval_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      p1_fiber_reg <= !p1_copper_next;
      p2_fiber_reg <= !p2_copper_next;
      spi_reg <= (bus_mode_next == PMNP_BUS_SPI);
      mdio_reg <= (bus_mode_next == PMNP_BUS_MDIO);
      inval_reg <= !bus_mode_next[1] && (strap_st_next == PMNP_STRAP_DONE);
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign port1_fiber = p1_fiber_reg;
  assign port2_fiber = p2_fiber_reg;
  assign host_spi_sel = spi_reg;
  assign host_mdio_sel = mdio_reg;
  assign host_mode_invalid = inval_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_STRAP_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    (strap_st_reg == PMNP_STRAP_CAPTURE) |=> bus_mode_reg == $past(strap_s2_reg))
    else $error("strap level not captured into bus mode");

  AST_P2_MEDIA: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_media && strap_st_reg == PMNP_STRAP_DONE)
      |=> port2_fiber == !$past(reg_wdata[`PMNP_BIT_P2_COPPER]))
    else $error("port 2 media select wrong");

  AST_P1_MEDIA: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_media && strap_st_reg == PMNP_STRAP_DONE)
      |=> port1_fiber == !$past(reg_wdata[`PMNP_BIT_P1_COPPER]))
    else $error("port 1 media select wrong");

  AST_BUS_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 (host_spi_sel == (bus_mode_reg == PMNP_BUS_SPI))
      && (host_mdio_sel == (bus_mode_reg == PMNP_BUS_MDIO)))
    else $error("host bus mode decode wrong");

  AST_NP_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_np |=> reg_rvalid && reg_rdata == $past(np_word) && !reg_rdata[`PMNP_BIT_NP_RSVD])
    else $error("next page read data wrong");

  AST_RSVD_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_media |=> reg_rdata[15:8] == `PMNP_RO_HI_RST && reg_rdata[5:4] == `PMNP_RO_54_RST)
    else $error("reserved media bits not at default");

  AST_NP_NO_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_wr && hit(reg_addr, `PMNP_OFS_NP_TX) && !np_load && !np_exchanged && !base_page_sent)
      |=> $stable(np_word))
    else $error("write changed read-only next page register");
endmodule
`default_nettype wire

// file: sim/pmnp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmnp_regs.svh"

module pmnp_host_model
(
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output pmnp_pkg::pmnp_word_t reg_wdata,
  input wire pmnp_pkg::pmnp_word_t reg_rdata,
  input wire logic reg_rvalid
);
  import pmnp_pkg::*;

  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0000;
    reg_wdata = 16'h0000;
  end

  // One strobe cycle; strobes drop to zero, address and write data show inverted values afterwards
  task automatic cycle(input logic wr, input logic [11:0] a, input pmnp_word_t d,
                       output pmnp_word_t q, output logic v);
    @(posedge core_clk);
    #1;
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    q = reg_rdata;
    v = reg_rvalid;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic wr(input logic [11:0] a, input pmnp_word_t d);
    pmnp_word_t q;
    logic v;
    cycle(1'b1, a, d, q, v);
    // Software follows a fiber selection with the front-end clear
    if (a == `PMNP_OFS_MEDIA_MODE && d[7:6] != 2'h3)
    begin
      cycle(1'b1, 12'h0734, 16'hdfff, q, v);
    end
  endtask
endmodule

`default_nettype wire

// file: sim/port_mode_and_next_page_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmnp_regs.svh"

module port_mode_and_next_page_regs_bench;
  import pmnp_pkg::*;

  typedef struct packed {pmnp_word_t wd; pmnp_word_t rd; logic [4:0] outs;} pmnp_row_t;
  logic core_clk;
  logic resetn;
  logic [1:0] strap_rxd;
  logic base_page_sent;
  logic base_toggle_bit;
  logic np_load;
  logic np_more_pages;
  logic np_message_page;
  logic np_comply;
  pmnp_code_t np_code;
  logic np_exchanged;
  wire logic reg_wr;
  wire logic reg_rd;
  wire logic [11:0] reg_addr;
  wire pmnp_word_t reg_wdata;
  wire pmnp_word_t reg_rdata;
  wire logic reg_rvalid;
  wire logic port1_fiber;
  wire logic port2_fiber;
  wire logic host_spi_sel;
  wire logic host_mdio_sel;
  wire logic host_mode_invalid;
  int err_count;
  int num_checks;
  // Outputs: port2 fiber, port1 fiber, spi, mdio, invalid
  pmnp_row_t rows [4] = '{
    '{16'hffff, 16'h00ff, 5'b00010},
    '{16'h0000, 16'h0030, 5'b11001},
    '{16'h0042, 16'h0072, 5'b10100},
    '{16'h0081, 16'h00b1, 5'b01001}};

  pmnp_top dut_u (.core_clk(core_clk), .resetn(resetn), .strap_rxd(strap_rxd),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .base_page_sent(base_page_sent),
    .base_toggle_bit(base_toggle_bit), .np_load(np_load), .np_more_pages(np_more_pages),
    .np_message_page(np_message_page), .np_comply(np_comply), .np_code(np_code),
    .np_exchanged(np_exchanged), .port1_fiber(port1_fiber), .port2_fiber(port2_fiber),
    .host_spi_sel(host_spi_sel), .host_mdio_sel(host_mdio_sel),
    .host_mode_invalid(host_mode_invalid));

  pmnp_host_model host_u (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input pmnp_word_t got, input pmnp_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input pmnp_word_t exp);
    pmnp_word_t q;
    logic v;
    host_u.cycle(1'b0, a, 16'h0000, q, v);
    chk(16'(v), 16'h0001);
    chk(q, exp);
  endtask

  task automatic do_reset(input logic [1:0] code);
    @(posedge core_clk);
    #1;
    resetn = 1'b0;
    strap_rxd = code;
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'({port1_fiber, port2_fiber, host_spi_sel, host_mdio_sel, reg_rvalid}), 16'h0000);
    chk(reg_rdata, 16'h0000);
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic np_pulse(input logic ld, input logic base, input logic exch);
    @(posedge core_clk);
    #1;
    np_load = ld;
    base_page_sent = base;
    np_exchanged = exch;
    @(posedge core_clk);
    #1;
    np_load = 1'b0;
    base_page_sent = 1'b0;
    np_exchanged = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #20000;
    err_count++;
    close_out();
  end

  initial
  begin
    err_count = 0;
    num_checks = 0;
    resetn = 1'b0;
    strap_rxd = 2'h0;
    {base_page_sent, base_toggle_bit, np_load, np_exchanged} = 4'h0;
    {np_more_pages, np_message_page, np_comply} = 3'h0;
    np_code = 11'h000;
    for (int c = 0; c < 4; c++)
    begin
      do_reset(2'(c));
      rd_chk(`PMNP_OFS_MEDIA_MODE, 16'h00fc | 16'(c));
      chk(16'({host_spi_sel, host_mdio_sel, host_mode_invalid}),
          16'((c == 2) ? 3'h4 : (c == 3) ? 3'h2 : 3'h1));
    end
    foreach (rows[i])
    begin
      host_u.wr(`PMNP_OFS_MEDIA_MODE, rows[i].wd);
      chk(16'({port2_fiber, port1_fiber, host_spi_sel, host_mdio_sel, host_mode_invalid}),
          16'(rows[i].outs));
      rd_chk(`PMNP_OFS_MEDIA_MODE, rows[i].rd);
    end
    rd_chk(`PMNP_OFS_NP_TX, 16'h2001);
    host_u.wr(`PMNP_OFS_NP_TX, 16'hffff);
    rd_chk(`PMNP_OFS_NP_TX, 16'h2001);
    rd_chk(12'h0734, 16'h0000);
    {np_more_pages, np_message_page, np_comply, np_code} = {3'h5, 11'h5a5};
    np_pulse(1'b1, 1'b0, 1'b0);
    rd_chk(`PMNP_OFS_NP_TX, 16'h95a5);
    {np_more_pages, np_message_page, np_comply, np_code} = {3'h2, 11'h7ff};
    np_pulse(1'b1, 1'b0, 1'b0);
    rd_chk(`PMNP_OFS_NP_TX, 16'h27ff);
    base_toggle_bit = 1'b0;
    np_pulse(1'b0, 1'b1, 1'b0);
    rd_chk(`PMNP_OFS_NP_TX, 16'h2fff);
    np_pulse(1'b0, 1'b0, 1'b1);
    rd_chk(`PMNP_OFS_NP_TX, 16'h27ff);
    np_pulse(1'b0, 1'b0, 1'b1);
    rd_chk(`PMNP_OFS_NP_TX, 16'h2fff);
    // Base page wins over a same-cycle exchange
    base_toggle_bit = 1'b1;
    np_pulse(1'b0, 1'b1, 1'b1);
    rd_chk(`PMNP_OFS_NP_TX, 16'h27ff);
    close_out();
  end
endmodule

`default_nettype wire
